// ---- common/led_strap_pkg.sv ----
// Constants for the status LED and strap block
package led_strap_pkg;

    // ************************************************************
    // Register map (byte addresses, 32-bit words)
    // ************************************************************
    localparam logic [3:0] CTRL_OFFSET     = 4'h0;
    localparam logic [3:0] LED_MODE_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET   = 4'h8;
    localparam int         ADDR_WIDTH      = 4;

    // Control word fields
    localparam int DUPLEX_BIT_POS  = 8;
    localparam int AUTONEG_BIT_POS = 12;

    // Status word fields
    localparam int STAT_POWER_DOWN_POS = 0;
    localparam int STAT_LINK_POS       = 1;
    localparam int STAT_SPEED_POS      = 2;
    localparam int STAT_FULL_POS       = 3;
    localparam int STAT_STRAP_DONE_POS = 4;

    // ************************************************************
    // LED modes
    // ************************************************************
    localparam logic [1:0] LED_MODE_RESET = 2'h0;
    localparam logic [1:0] LED_MODE_00    = 2'h0;
    localparam logic [1:0] LED_MODE_01    = 2'h1;
    localparam logic [1:0] LED_MODE_10    = 2'h2;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS    = 8;
    // Half period of the activity and collision blink
    localparam int BLINK_TIME_MS    = 50;
    localparam int BLINK_CYCLES     = (BLINK_TIME_MS * 1000000) / CLK_PERIOD_NS;
    // Cycles after reset release before the straps are taken
    localparam int STRAP_SETTLE_CYC = 4;
    localparam int SYNC_STAGES      = 3;

    // Strap control states
    typedef enum logic [1:0] {
        ST_SETTLE = 2'b01,
        ST_DRIVE  = 2'b10
    } strap_state_t;

endpackage : led_strap_pkg

// ---- rtl/pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic pin_in,
    output var  logic level_out
);
    import led_strap_pkg::*;

    logic [SYNC_STAGES-1:0] stage_q;
    logic                   level_q;

    // Shift chain runs free so straps are seen while reset is held
    always_ff @(posedge core_clk) begin
        stage_q <= {stage_q[SYNC_STAGES-2:0], pin_in};
    end

    // Change counts once stages two and three agree
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            level_q <= 1'b1;
        end else if (stage_q[1] == stage_q[2]) begin
            level_q <= stage_q[2];
        end
    end

    assign level_out = level_q;
endmodule : pin_sync
`default_nettype wire

// ---- rtl/led_strap_outputs.sv ----
// Status LED drivers, strap capture and register slave
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - In mode 01 the speed LED is lit at 100 Mb/s and dark at 10 Mb/s.
// - In mode 10 the speed LED is lit only with a 100 Mb/s link up, dark without link.
// - In modes 00 and 10 the duplex LED is lit for full duplex and dark for half.
// - In mode 01 the duplex LED shows full duplex and toggles every blink half period while collision is high.
// - In modes 01 and 10 the third LED toggles with traffic and is idle otherwise.
// - The duplex pin is sampled at reset as a strap into control bit 8.
// - The third LED pin is sampled at reset as a strap into control bit 12.
// - All LED outputs are active low, low means lit.
// - A high power-down input means normal work, a low one means power-down.
module led_strap_outputs #(
    parameter int BLINK_CYC = led_strap_pkg::BLINK_CYCLES
) (
    input  wire logic                               core_clk,
    input  wire logic                               rstn,
    // Line state from the transceiver core
    input  wire logic                               speed_100,
    input  wire logic                               link_up,
    input  wire logic                               full_duplex,
    input  wire logic                               collision,
    input  wire logic                               activity,
    // Pins
    input  wire logic                               power_down_n,
    output var  logic                               speed_indicator_out,
    input  wire logic                               duplex_pin_in,
    output var  logic                               duplex_indicator_out,
    output var  logic                               duplex_pin_oe,
    input  wire logic                               autoneg_strap,
    output var  logic                               collision_activity_indicator_out,
    output var  logic                               collision_activity_pin_oe,
    // Control bits to the core
    output var  logic                               duplex_mode_bit,
    output var  logic                               autoneg_enable_bit,
    output var  logic                               power_down,
    // Avalon-MM slave
    input  wire logic [led_strap_pkg::ADDR_WIDTH-1:0] avs_address,
    input  wire logic                               avs_read,
    input  wire logic                               avs_write,
    input  wire logic [31:0]                        avs_writedata,
    input  wire logic [3:0]                         avs_byteenable,
    output var  logic [31:0]                        avs_readdata,
    output var  logic                               avs_waitrequest
);
    import led_strap_pkg::*;

    localparam logic [22:0] BLINK_LAST = 23'(BLINK_CYC - 1);
    localparam logic [2:0]  SETTLE_LAST = 3'(STRAP_SETTLE_CYC - 1);

    logic         pd_n_sync;
    logic         duplex_sync;
    logic         autoneg_sync;
    strap_state_t state_q;
    logic [2:0]   settle_q;
    logic [22:0]  blink_cnt_q;
    logic         blink_tick_q;
    logic [1:0]   led_mode_q;
    logic         duplex_bit_q;
    logic         autoneg_bit_q;
    logic         pd_q;
    logic         act_phase_q;
    logic         col_phase_q;
    logic         speed_led_q;
    logic         duplex_led_q;
    logic         third_led_q;
    logic         duplex_oe_q;
    logic         third_oe_q;
    logic         wait_q;
    logic [31:0]  rdata_q;
    logic         bus_req;
    logic         wr_take;
    logic         strap_take;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] pin_raw;
    logic [2:0] pin_level;
    assign pin_raw = {power_down_n, duplex_pin_in, autoneg_strap};

    // One synchroniser per incoming pin
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            pin_sync u_sync (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .pin_in    (pin_raw[gi]),
                .level_out (pin_level[gi])
            );
        end
    endgenerate

    assign pd_n_sync    = pin_level[2];
    assign duplex_sync  = pin_level[1];
    assign autoneg_sync = pin_level[0];

    // ************************************************************
    // Strap capture sequence
    // ************************************************************
    assign strap_take = (state_q == ST_SETTLE) && (settle_q == SETTLE_LAST);

    // Wait for the synchroniser to refill before trusting the pins
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q  <= ST_SETTLE;
            settle_q <= 3'h0;
        end else begin
            unique case (state_q)
                ST_SETTLE: begin
                    settle_q <= settle_q + 3'h1;
                    if (strap_take) begin
                        state_q <= ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    state_q <= ST_DRIVE;
                end
            endcase
        end
    end

    // Pin drivers off in reset so strap resistors set the level
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            duplex_oe_q <= 1'b0;
            third_oe_q  <= 1'b0;
        end else begin
            duplex_oe_q <= (state_q == ST_DRIVE);
            third_oe_q  <= (state_q == ST_DRIVE);
        end
    end

    // ************************************************************
    // Control register bits
    // ************************************************************
    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write && !wait_q;

    // Strap load wins over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            duplex_bit_q  <= 1'b0;
            autoneg_bit_q <= 1'b0;
        end else if (strap_take) begin
            duplex_bit_q  <= duplex_sync;
            autoneg_bit_q <= autoneg_sync;
        end else if (wr_take && avs_address == CTRL_OFFSET && avs_byteenable[1]) begin
            duplex_bit_q  <= avs_writedata[DUPLEX_BIT_POS];
            autoneg_bit_q <= avs_writedata[AUTONEG_BIT_POS];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            led_mode_q <= LED_MODE_RESET;
        end else if (wr_take && avs_address == LED_MODE_OFFSET && avs_byteenable[0]) begin
            led_mode_q <= avs_writedata[1:0];
        end
    end

    // power-down follows the low pin level
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= !pd_n_sync;
        end
    end

    // ************************************************************
    // Blink timebase
    // ************************************************************
    // One-cycle enable every blink half period
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            blink_cnt_q  <= 23'h0;
            blink_tick_q <= 1'b0;
        end else begin
            blink_tick_q <= (blink_cnt_q == BLINK_LAST);
            if (blink_cnt_q == BLINK_LAST) begin
                blink_cnt_q <= 23'h0;
            end else begin
                blink_cnt_q <= blink_cnt_q + 23'h1;
            end
        end
    end

    // Blink phases clear once the cause stops: third LED goes dark, duplex LED shows plain duplex
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            act_phase_q <= 1'b0;
            col_phase_q <= 1'b0;
        end else begin
            if (!activity) begin
                act_phase_q <= 1'b0;
            end else if (blink_tick_q) begin
                act_phase_q <= !act_phase_q;
            end
            if (!collision) begin
                col_phase_q <= 1'b0;
            end else if (blink_tick_q) begin
                col_phase_q <= !col_phase_q;
            end
        end
    end

    // ************************************************************
    // LED drivers, low means lit
    // ************************************************************
    // Dark in power-down and in the undefined mode 11
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            speed_led_q  <= 1'b1;
            duplex_led_q <= 1'b1;
            third_led_q  <= 1'b1;
        end else if (pd_q) begin
            speed_led_q  <= 1'b1;
            duplex_led_q <= 1'b1;
            third_led_q  <= 1'b1;
        end else begin
            case (led_mode_q)
                LED_MODE_00: begin
                    speed_led_q  <= !speed_100;
                    duplex_led_q <= !full_duplex;
                    third_led_q  <= !collision;
                end
                LED_MODE_01: begin
                    speed_led_q  <= !speed_100;
                    duplex_led_q <= !full_duplex ^ col_phase_q;
                    third_led_q  <= !act_phase_q;
                end
                LED_MODE_10: begin
                    // lit only with 100 Mb/s link
                    speed_led_q  <= !(speed_100 && link_up);
                    duplex_led_q <= !full_duplex;
                    third_led_q  <= !act_phase_q;
                end
                default: begin
                    speed_led_q  <= 1'b1;
                    duplex_led_q <= 1'b1;
                    third_led_q  <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Avalon-MM slave, one wait cycle per access
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(bus_req && wait_q);
        end
    end

    // Read data settles with waitrequest low; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else if (avs_read && wait_q) begin
            rdata_q <= 32'h0000_0000;
            unique case (avs_address)
                CTRL_OFFSET: begin
                    rdata_q[DUPLEX_BIT_POS]  <= duplex_bit_q;
                    rdata_q[AUTONEG_BIT_POS] <= autoneg_bit_q;
                end
                LED_MODE_OFFSET: begin
                    rdata_q[1:0] <= led_mode_q;
                end
                STATUS_OFFSET: begin
                    rdata_q[STAT_POWER_DOWN_POS] <= pd_q;
                    rdata_q[STAT_LINK_POS]       <= link_up;
                    rdata_q[STAT_SPEED_POS]      <= speed_100;
                    rdata_q[STAT_FULL_POS]       <= full_duplex;
                    rdata_q[STAT_STRAP_DONE_POS] <= (state_q == ST_DRIVE);
                end
                default: begin
                    rdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ************************************************************
    // Output wiring, all from flip-flops
    // ************************************************************
    assign speed_indicator_out              = speed_led_q;
    assign duplex_indicator_out             = duplex_led_q;
    assign duplex_pin_oe                    = duplex_oe_q;
    assign collision_activity_indicator_out = third_led_q;
    assign collision_activity_pin_oe        = third_oe_q;
    assign duplex_mode_bit                  = duplex_bit_q;
    assign autoneg_enable_bit               = autoneg_bit_q;
    assign power_down                       = pd_q;
    assign avs_readdata                     = rdata_q;
    assign avs_waitrequest                  = wait_q;

endmodule : led_strap_outputs
`default_nettype wire

// ---- testbench/led_strap_assertions.sv ----
// Port checker for the LED and strap block
`timescale 1ns/1ns
`default_nettype none
module led_strap_checker
    import led_strap_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        speed_100,
    input wire logic        link_up,
    input wire logic        full_duplex,
    input wire logic        collision,
    input wire logic        power_down_n,
    input wire logic        speed_indicator_out,
    input wire logic        duplex_pin_in,
    input wire logic        duplex_indicator_out,
    input wire logic        duplex_pin_oe,
    input wire logic        autoneg_strap,
    input wire logic        collision_activity_indicator_out,
    input wire logic        collision_activity_pin_oe,
    input wire logic        duplex_mode_bit,
    input wire logic        autoneg_enable_bit,
    input wire logic        power_down,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest
);
    logic [1:0] mode_q;
    logic       run;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // LEDs only follow the core once straps are in and power is up
    assign run = !power_down && collision_activity_pin_oe;
    // Mirror of the mode field, taken at the bus edge
    always_ff @(posedge core_clk) begin
        if (!rstn)
            mode_q <= LED_MODE_RESET;
        else if (avs_write && !avs_waitrequest && avs_address == LED_MODE_OFFSET
                 && avs_byteenable[0])
            mode_q <= avs_writedata[1:0];
    end
    speed_mode01_a: assert property (mode_q == LED_MODE_01 && run ##1 run
        |-> speed_indicator_out == !$past(speed_100)) else $error("speed LED mode 01");
    speed_mode10_a: assert property (mode_q == LED_MODE_10 && run ##1 run
        |-> speed_indicator_out == !$past(speed_100 && link_up)) else $error("speed mode 10");
    duplex_led_a: assert property (mode_q != LED_MODE_01 && mode_q[0] == 1'b0 && run
        ##1 run |-> duplex_indicator_out == !$past(full_duplex)) else $error("duplex LED");
    coll_mode00_a: assert property (mode_q == LED_MODE_00 && run ##1 run
        |-> collision_activity_indicator_out == !$past(collision)) else $error("collision LED");
    pd_dark_a: assert property (power_down |=> speed_indicator_out
        && duplex_indicator_out && collision_activity_indicator_out) else $error("LED lit in pd");
    pd_enter_a: assert property (!power_down_n [*6] |=> power_down)
        else $error("power-down not entered");
    oe_reset_a: assert property (disable iff (1'b0) !rstn |=> !duplex_pin_oe
        && !collision_activity_pin_oe) else $error("pin driven in reset");
    oe_release_a: assert property ($rose(rstn) |-> ##1 !duplex_pin_oe [*4]
        ##1 duplex_pin_oe && collision_activity_pin_oe) else $error("pin drive timing");
    strap_load_a: assert property ($rose(rstn) |-> ##4 duplex_mode_bit ==
        $past(duplex_pin_in, 4) && autoneg_enable_bit == $past(autoneg_strap, 4))
        else $error("strap value not loaded");
    bus_wait_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest
        ##1 avs_waitrequest) else $error("bus answer timing");
    cover property (mode_q == LED_MODE_01 && $fell(collision_activity_indicator_out));
    cover property ($rose(power_down));
    cover property ($rose(duplex_pin_oe));
endmodule : led_strap_checker
bind led_strap_outputs led_strap_checker chk (.*);
`default_nettype wire

// ---- testbench/board_model.sv ----
// Board side: strap resistors on the two dual-purpose pins
`timescale 1ns/1ns
`default_nettype none
module board_model (
    input  wire logic dup_pull,
    input  wire logic aneg_pull,
    input  wire logic duplex_indicator_out,
    input  wire logic duplex_pin_oe,
    input  wire logic collision_activity_indicator_out,
    input  wire logic collision_activity_pin_oe,
    output var  logic duplex_pin_in,
    output var  logic autoneg_strap
);
    always_comb begin
        duplex_pin_in = duplex_pin_oe ? duplex_indicator_out : dup_pull;
        autoneg_strap = collision_activity_pin_oe ? collision_activity_indicator_out : aneg_pull;
    end
endmodule : board_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the LED and strap block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
    import led_strap_pkg::*;
    logic        core_clk, rstn, speed_100, link_up, full_duplex, collision, activity;
    logic        power_down_n, dup_pull, aneg_pull, avs_read, avs_write, avs_waitrequest;
    logic        speed_indicator_out, duplex_indicator_out, collision_activity_indicator_out;
    logic        duplex_pin_in, duplex_pin_oe, autoneg_strap, collision_activity_pin_oe;
    logic        duplex_mode_bit, autoneg_enable_bit, power_down, p2, p3;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          n_errors = 0, num_checks = 0, cyc = 0, k, t2, t3;
    // Rows: mode, speed, link, full, collision | speed, duplex, third LED
    logic [8:0]  rows [8] = '{9'b00_1110_001, 9'b00_0001_110, 9'b01_1000_011,
        9'b01_0110_101, 9'b10_1100_011, 9'b10_1010_101, 9'b10_0110_101, 9'b11_1111_111};

    led_strap_outputs #(.BLINK_CYC(8)) dut (.*);
    board_model board (.*);

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Hang guard, far above the fewer than 200 cycles needed
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end
    // One Avalon access; only the hang guard may end the wait
    task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, speed_100, link_up, full_duplex, collision, activity} = 6'h00;
        {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
        {power_down_n, dup_pull, aneg_pull} = 3'b110;
        repeat (6) @(posedge core_clk);
        `CHK({duplex_pin_oe, collision_activity_pin_oe}, 2'b00)
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus(1'b0, CTRL_OFFSET, 4'hf, 32'h0);
        `CHK({rd[DUPLEX_BIT_POS], rd[AUTONEG_BIT_POS]}, 2'b10)
        bus(1'b0, LED_MODE_OFFSET, 4'hf, 32'h0);
        `CHK(rd[1:0], 2'b00)
        // Software write of the control bits; lane 1 gates it
        bus(1'b1, CTRL_OFFSET, 4'h2, 32'h0000_0100);
        `CHK({duplex_mode_bit, autoneg_enable_bit}, 2'b10)
        bus(1'b1, CTRL_OFFSET, 4'h1, 32'h0000_1000);
        `CHK({duplex_mode_bit, autoneg_enable_bit}, 2'b10)
        for (k = 0; k < 8; k++) begin
            bus(1'b1, LED_MODE_OFFSET, 4'h1, {30'h0, rows[k][8:7]});
            {speed_100, link_up, full_duplex, collision} <= rows[k][6:3];
            repeat (3) @(posedge core_clk);
            `CHK({speed_indicator_out, duplex_indicator_out, collision_activity_indicator_out}, rows[k][2:0])
        end
        // Mode 01: traffic and collision both blink
        bus(1'b1, LED_MODE_OFFSET, 4'h1, 32'h0000_0001);
        {collision, activity} <= 2'b11;
        {t2, t3, p2, p3} = {64'h0, 2'b01};
        repeat (40) begin
            @(posedge core_clk);
            if (duplex_indicator_out !== p2) t2++;
            if (collision_activity_indicator_out !== p3) t3++;
            {p2, p3} = {duplex_indicator_out, collision_activity_indicator_out};
        end
        `CHK(t3 >= 3, 1'b1)
        `CHK(t2 >= 3, 1'b1)
        {collision, activity} <= 2'b00;
        repeat (3) @(posedge core_clk);
        `CHK({duplex_indicator_out, collision_activity_indicator_out}, 2'b01)
        // Power-down darkens the speed and duplex LEDs and shows in status
        power_down_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        `CHK({power_down, speed_indicator_out, duplex_indicator_out}, 3'b111)
        bus(1'b0, STATUS_OFFSET, 4'hf, 32'h0);
        `CHK(rd[STAT_POWER_DOWN_POS], 1'b1)
        `CHK(rd[4:0], 5'h1f)
        power_down_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        `CHK(power_down, 1'b0)
        bus(1'b0, 4'hc, 4'hf, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Second reset with the straps reversed
        {rstn, dup_pull, aneg_pull} <= 3'b001;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge core_clk);
        `CHK({duplex_mode_bit, autoneg_enable_bit}, 2'b01)
        conclude();
    end
endmodule : tb_top
`default_nettype wire
